//--- swc_top.sv
/*
  Shutdown/wake-up controller top: AXI4-Lite slave, keyed power-off,
  wake detection, sticky status with mask and interrupt.
  Assumes all inputs synchronous to the slow clock except alarm_in.
*/
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
module swc_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic wake_pin_in,
  input wire logic alarm_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic power_off_out,
  output logic irq
);
  logic alarm_sync;
  logic pin_wake;
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_nxt, awready_nxt, wready_nxt, arready_nxt, rvalid_nxt;
  logic [1:0] bresp_nxt, rresp_nxt;
  logic [31:0] rdata_nxt;
  logic [31:0] cfg_r, cfg_nxt;
  logic [1:0] status_r, status_nxt;
  logic [1:0] mask_r, mask_nxt;
  logic [1:0] off_pipe_r, off_pipe_nxt;
  logic power_off_nxt, irq_nxt;
  logic alarm_prev_r, alarm_prev_nxt;
  logic do_write, do_read, cmd_go, alarm_wake, status_rd;
  logic [1:0] events;

  function automatic logic mapped(input logic [7:0] a);
    mapped = a == swc_pkg::CMD_OFF || a == swc_pkg::CFG_OFF ||
             a == swc_pkg::STS_OFF || a == swc_pkg::MSK_OFF;
  endfunction

  swc_sync alarm_sync_u (
    .clock(clock),
    .rst(rst),
    .clk_en(clk_en),
    .d(alarm_in),
    .q(alarm_sync)
  );

  swc_debounce pin_u ( // R12
    .clock(clock),
    .rst(rst),
    .clk_en(clk_en),
    .pin(wake_pin_in),
    .edge_sel(cfg_r[swc_pkg::EDGE_LSB +: 2]),
    .debounce_count(cfg_r[swc_pkg::DEBOUNCE_LSB +: swc_pkg::DEBOUNCE_W]),
    .wake_pulse(pin_wake)
  );

  // bus channels
  always_comb
  begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    awready_nxt = 1'b0;
    wready_nxt = 1'b0;
    bvalid_nxt = s_axi_bvalid;
    bresp_nxt = s_axi_bresp;
    arready_nxt = 1'b0;
    rvalid_nxt = s_axi_rvalid;
    rresp_nxt = s_axi_rresp;
    rdata_nxt = s_axi_rdata;
    do_write = 1'b0;
    do_read = 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (!aw_got_r && !s_axi_awready && !s_axi_bvalid)
      awready_nxt = s_axi_awvalid;
    if (!w_got_r && !s_axi_wready && !s_axi_bvalid)
      wready_nxt = s_axi_wvalid;
    if (aw_got_r && w_got_r && !s_axi_bvalid)
    begin
      do_write = 1'b1;
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = mapped(awaddr_r) ? swc_pkg::RESP_OKAY
                                   : swc_pkg::RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      bvalid_nxt = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      do_read = 1'b1;
      rvalid_nxt = 1'b1;
      rresp_nxt = mapped(s_axi_araddr) ? swc_pkg::RESP_OKAY
                                       : swc_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        swc_pkg::CFG_OFF: rdata_nxt = cfg_r;
        swc_pkg::STS_OFF: rdata_nxt = {30'h0, status_r};
        swc_pkg::MSK_OFF: rdata_nxt = {30'h0, mask_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      rvalid_nxt = 1'b0;
    if (!s_axi_rvalid && !s_axi_arready)
      arready_nxt = s_axi_arvalid;
  end

  // registers, power-off and status
  always_comb
  begin
    cfg_nxt = cfg_r;
    mask_nxt = mask_r;
    // strobes travel with the data; an all-zero strobe voids a command
    cmd_go = do_write && awaddr_r == swc_pkg::CMD_OFF && wdata_r[
      swc_pkg::POWER_OFF_BIT] && wdata_r[swc_pkg::KEY_LSB +: 8] ==
      swc_pkg::KEY_VALUE && wstrb_r != 4'h0; // R2
    if (do_write && awaddr_r == swc_pkg::CFG_OFF)
      cfg_nxt = wdata_r;
    if (do_write && awaddr_r == swc_pkg::MSK_OFF)
      mask_nxt = wdata_r[1:0];
    alarm_prev_nxt = alarm_sync;
    alarm_wake = cfg_r[swc_pkg::ALARM_EN_BIT] && alarm_sync &&
                 !alarm_prev_r; // R8 R10
    events = {alarm_wake, pin_wake}; // R9
    status_rd = do_read && s_axi_araddr == swc_pkg::STS_OFF;
    status_nxt = (status_rd ? 2'h0 : status_r) | events; // R7 R9
    off_pipe_nxt = {off_pipe_r[0], cmd_go}; // R1
    power_off_nxt = power_off_out;
    if (off_pipe_r[1])
      power_off_nxt = 1'b1; // R1
    else if (pin_wake || alarm_wake)
      power_off_nxt = 1'b0; // R5 R8 R11
    irq_nxt = |(status_nxt & mask_nxt);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      s_axi_awready <= awready_nxt;
      s_axi_wready <= wready_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_bresp <= bresp_nxt;
      s_axi_arready <= arready_nxt;
      s_axi_rvalid <= rvalid_nxt;
      s_axi_rresp <= rresp_nxt;
      s_axi_rdata <= rdata_nxt;
    end
  end

  // control state on the always-on clock
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cfg_r <= swc_pkg::CFG_RESET;
      mask_r <= 2'h0;
      status_r <= 2'h0;
      off_pipe_r <= 2'h0;
      alarm_prev_r <= 1'b0;
      power_off_out <= 1'b0;
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      cfg_r <= cfg_nxt;
      mask_r <= mask_nxt;
      status_r <= status_nxt;
      off_pipe_r <= off_pipe_nxt;
      alarm_prev_r <= alarm_prev_nxt;
      power_off_out <= power_off_nxt;
      irq <= irq_nxt;
    end
  end

  // power-off and wake checks
  off_delay_a: assert property (@(posedge clock) disable iff (rst) // R1
    (clk_en && cmd_go) ##1 clk_en ##1 clk_en |=> power_off_out)
    else $error("power-off not raised two cycles after command");
  bad_key_a: assert property (@(posedge clock) disable iff (rst) // R2
    (do_write && wdata_r[31:24] != swc_pkg::KEY_VALUE) |-> !cmd_go)
    else $error("command taken without key");
  strobe_block_a: assert property (@(posedge clock) disable iff (rst) // R2
    (do_write && wstrb_r == 4'h0) |-> !cmd_go)
    else $error("command taken with no byte strobes");
  pin_flag_a: assert property (@(posedge clock) disable iff (rst) // R7
    (clk_en && pin_wake) |=> status_r[0])
    else $error("pin wake flag not set");
  alarm_flag_a: assert property (@(posedge clock) disable iff (rst) // R8 R9
    (clk_en && alarm_wake && !off_pipe_r[1]) |=>
    status_r[1] && !power_off_out)
    else $error("alarm wake not recorded");
  read_clear_a: assert property (@(posedge clock) disable iff (rst) // R7
    (clk_en && status_rd && events == 2'h0) |=> status_r == 2'h0)
    else $error("status not cleared by read");
  flag_hold_a: assert property (@(posedge clock) disable iff (rst) // R7 R9
    (clk_en && !status_rd && events == 2'h0) |=> $stable(status_r))
    else $error("status changed without event or read");
  hold_off_a: assert property (@(posedge clock) disable iff (rst) // R11
    (power_off_out && !pin_wake && !alarm_wake) |=> power_off_out)
    else $error("power-off dropped without wake");
  stay_on_a: assert property (@(posedge clock) disable iff (rst) // R11
    (!power_off_out && !off_pipe_r[1]) |=> !power_off_out)
    else $error("power-off raised without command");
  off_wins_a: assert property (@(posedge clock) disable iff (rst) // R1
    (clk_en && off_pipe_r[1]) |=> power_off_out)
    else $error("power-off not raised at end of delay");
  pin_release_a: assert property (@(posedge clock) disable iff (rst) // R5 R11
    (clk_en && pin_wake && !off_pipe_r[1]) |=> !power_off_out)
    else $error("pin wake did not release power-off");
  irq_gate_a: assert property (@(posedge clock) disable iff (rst)
    clk_en |=> irq == |(status_r & mask_r))
    else $error("interrupt does not follow status and mask");
  alarm_off_a: assert property (@(posedge clock) disable iff (rst) // R8
    !cfg_r[swc_pkg::ALARM_EN_BIT] |-> !alarm_wake)
    else $error("alarm wake while disabled");
  state_freeze_a: assert property (@(posedge clock) disable iff (rst)
    !clk_en |=> $stable(power_off_out) && $stable(status_r) &&
    $stable(irq))
    else $error("state moved while clock enable low");

  // bus handshake checks
  aw_pulse_a: assert property (@(posedge clock) disable iff (rst)
    (clk_en && s_axi_awready) |=> !s_axi_awready)
    else $error("write address ready held over two cycles");
  w_pulse_a: assert property (@(posedge clock) disable iff (rst)
    (clk_en && s_axi_wready) |=> !s_axi_wready)
    else $error("write data ready held over two cycles");
  ar_pulse_a: assert property (@(posedge clock) disable iff (rst)
    (clk_en && s_axi_arready) |=> !s_axi_arready)
    else $error("read address ready held over two cycles");
  b_hold_a: assert property (@(posedge clock) disable iff (rst)
    (s_axi_bvalid && !s_axi_bready) |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  r_hold_a: assert property (@(posedge clock) disable iff (rst)
    (s_axi_rvalid && !s_axi_rready) |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  bad_addr_a: assert property (@(posedge clock) disable iff (rst)
    (clk_en && do_write && !mapped(awaddr_r)) |=>
    s_axi_bresp == swc_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");
  bad_read_a: assert property (@(posedge clock) disable iff (rst)
    (clk_en && do_read && !mapped(s_axi_araddr)) |=>
    s_axi_rresp == swc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");

  // scenario covers
  shutdown_c: cover property (@(posedge clock) disable iff (rst)
    cmd_go ##[1:8] power_off_out);
  pin_wake_c: cover property (@(posedge clock) disable iff (rst)
    power_off_out ##1 pin_wake ##1 !power_off_out);
  alarm_wake_c: cover property (@(posedge clock) disable iff (rst)
    power_off_out ##1 alarm_wake);
  freeze_c: cover property (@(posedge clock) disable iff (rst)
    (power_off_out && !clk_en) ##1 !clk_en);
  key_refused_c: cover property (@(posedge clock) disable iff (rst)
    do_write && awaddr_r == swc_pkg::CMD_OFF && !cmd_go);
endmodule // swc_top

//--- swc_pkg.sv
/*
  Constants for the shutdown/wake-up controller: register offsets, fields,
  key, reset values and timing.
  Assumes a single slow clock at 25 MHz, AXI4-Lite register access.
*/
// Overview of operation
// [R1] A keyed write with the power-off bit set raises the power-off output two slow-clock cycles later.
// [R2] A command write acts only if it carries the correct key, and software must always supply it.
// [R3] The wake edge select chooses rising, falling, any change, or disabled detection.
// [R4] The wake input is debounced, rejecting pulses shorter than debounce count times 16 cycles.
// [R5] A selected change starts a counter, and reaching the debounce value releases power-off.
// [R6] A new input change before the count completes stops and clears the counter; with any-change select the code clears and restarts the count instead.
// [R7] The pin wake flag sets on the selected event and clears when the status register is read.
// [R8] With alarm wake enabled, a synchronised alarm rising edge wakes and releases power-off.
// [R9] With alarm wake enabled, a detected alarm sets the alarm wake flag, cleared on status read.
// [R10] Software must clear the alarm status before power-off, or no rising edge will wake it; the code wakes on an enabled alarm rising edge whatever the status.
// [R11] Power-off holds until a qualified wake, then stays released until the next keyed command.
// [R12] All detection, counting and status logic runs on the always-on slow clock.
package swc_pkg;
  localparam logic [7:0] CMD_OFF = 8'h00;
  localparam logic [7:0] CFG_OFF = 8'h04;
  localparam logic [7:0] STS_OFF = 8'h08;
  localparam logic [7:0] MSK_OFF = 8'h0C;
  localparam logic [7:0] KEY_VALUE = 8'hA5;
  localparam int KEY_LSB = 24;
  localparam int POWER_OFF_BIT = 0;
  localparam int EDGE_LSB = 0;
  localparam int DEBOUNCE_LSB = 8;
  localparam int DEBOUNCE_W = 4;
  localparam int ALARM_EN_BIT = 16;
  localparam int PIN_FLAG_BIT = 0;
  localparam int ALARM_FLAG_BIT = 1;
  localparam int DEBOUNCE_UNIT = 16;
  localparam int CNT_W = 8;
  localparam int POWER_OFF_DELAY = 2;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_ANY
  } swc_edge_type;
endpackage

//--- swc_sync.sv
/*
  Two-flop synchroniser for the asynchronous alarm level.
  Assumes clock enable freezes state with the rest of the block.
*/
`timescale 1ns/1ns
module swc_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic d,
  output logic q
);
  logic meta_r;
  logic meta_nxt;
  logic q_nxt;
  always_comb
  begin
    meta_nxt = clk_en ? d : meta_r;
    q_nxt = clk_en ? meta_r : q;
  end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      meta_r <= meta_nxt;
      q <= q_nxt;
    end
  end
endmodule // swc_sync

//--- swc_debounce.sv
/*
  Wake pin edge detector and debounce counter.
  Assumes wake input synchronous to the slow clock.
*/
`timescale 1ns/1ns
module swc_debounce (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic pin,
  input wire logic [1:0] edge_sel,
  input wire logic [3:0] debounce_count,
  output logic wake_pulse
);
  logic prev_r;
  logic prev_nxt;
  logic armed_r;
  logic armed_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic wake_nxt;
  logic change;
  logic sel_hit;
  logic [7:0] target;
  always_comb
  begin
    change = pin != prev_r;
    target = 8'({debounce_count, 4'h0});
    unique case (swc_pkg::swc_edge_type'(edge_sel)) // R3
      swc_pkg::EDGE_OFF: sel_hit = 1'b0;
      swc_pkg::EDGE_RISE: sel_hit = change && pin;
      swc_pkg::EDGE_FALL: sel_hit = change && !pin;
      swc_pkg::EDGE_ANY: sel_hit = change;
    endcase
    prev_nxt = pin;
    armed_nxt = armed_r;
    cnt_nxt = cnt_r;
    wake_nxt = 1'b0;
    if (change)
    begin
      armed_nxt = sel_hit; // R6
      cnt_nxt = 8'h00; // R6
    end
    else if (armed_r)
    begin
      if (cnt_r >= target) // R4 R5
      begin
        wake_nxt = 1'b1;
        armed_nxt = 1'b0;
      end
      else
        cnt_nxt = cnt_r + 8'h01;
    end
    if (!clk_en)
    begin
      prev_nxt = prev_r;
      armed_nxt = armed_r;
      cnt_nxt = cnt_r;
      wake_nxt = wake_pulse;
    end
  end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      prev_r <= 1'b0;
      armed_r <= 1'b0;
      cnt_r <= 8'h00;
      wake_pulse <= 1'b0;
    end
    else
    begin
      prev_r <= prev_nxt;
      armed_r <= armed_nxt;
      cnt_r <= cnt_nxt;
      wake_pulse <= wake_nxt;
    end
  end
  glitch_reject_a: assert property (@(posedge clock) disable iff (rst) // R6
    (clk_en && change) |=> !wake_pulse)
    else $error("wake pulse right after input change");
endmodule // swc_debounce

//--- swc_partner.sv
/*
  Far-side model: wake push-button, alarm line and supply converter.
  Assumes the bench calls its tasks; lines change after a rising edge.
*/
`timescale 1ns/1ns
module swc_partner (
  input wire logic clock,
  input wire logic power_off_out,
  output logic wake_pin_in,
  output logic alarm_in,
  output logic supply_on
);
  initial
  begin
    wake_pin_in = 1'b0;
    alarm_in = 1'b0;
  end
  // converter runs while the shutdown request is low
  assign supply_on = !power_off_out;
  task automatic pin_to(input logic lvl);
    @(posedge clock);
    wake_pin_in <= lvl;
  endtask
  task automatic alarm_to(input logic lvl);
    @(posedge clock);
    alarm_in <= lvl;
  endtask
endmodule // swc_partner

//--- swc_top_bench.sv
/*
  Self-checking bench for the shutdown/wake-up controller.
  Assumes swc_pkg, swc_top and swc_partner are compiled first.
*/
`timescale 1ns/1ns
module swc_top_bench;
  logic clock, rst, clk_en;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, power_off_out, irq;
  logic wake_pin_in, alarm_in, supply_on;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [31:0] d;
  int miscompares = 0;
  int checked = 0;
  swc_top i_dut (.clock(clock), .rst(rst), .clk_en(clk_en),
    .wake_pin_in(wake_pin_in), .alarm_in(alarm_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .power_off_out(power_off_out), .irq(irq));
  swc_partner i_partner (.clock(clock), .power_off_out(power_off_out),
    .wake_pin_in(wake_pin_in), .alarm_in(alarm_in), .supply_on(supply_on));
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  function automatic logic [31:0] cfg(logic [1:0] e, logic [3:0] c,
    logic al);
    return {15'h0000, al, 4'h0, c, 6'h00, e};
  endfunction
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wait_po(input logic lvl, input int lim);
    int n;
    n = 0;
    while (power_off_out !== lvl && n < lim)
    begin
      @(posedge clock);
      n++;
    end
    chk(32'(power_off_out), 32'(lvl));
  endtask
  task automatic go_off();
    wr(swc_pkg::CMD_OFF, {swc_pkg::KEY_VALUE, 24'h000001});
    chk(32'(power_off_out), 32'h0);
    wait_po(1'b1, 4);
  endtask
  task automatic t_regs();
    rd(swc_pkg::CFG_OFF);
    chk(d, swc_pkg::CFG_RESET);
    wr(swc_pkg::CFG_OFF, cfg(2'h3, 4'hF, 1'b1));
    chk(32'(r), 32'(swc_pkg::RESP_OKAY));
    rd(swc_pkg::CFG_OFF);
    chk(d, 32'h0001_0F03);
    rd(8'hF0);
    chk(32'(r), 32'(swc_pkg::RESP_SLVERR));
    chk(d, 32'h0);
    wr(8'hF4, 32'h0000_0001);
    chk(32'(r), 32'(swc_pkg::RESP_SLVERR));
    rd(swc_pkg::CMD_OFF);
    chk(d, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_key();
    wr(swc_pkg::CMD_OFF, {8'h5A, 24'h000001});
    idle(8);
    chk(32'(power_off_out), 32'h0);
    go_off();
    idle(40);
    chk(32'(power_off_out), 32'h1);
    $display("test key done");
  endtask
  task automatic t_pin();
    wr(swc_pkg::CFG_OFF, cfg(2'h1, 4'h1, 1'b0));
    wr(swc_pkg::MSK_OFF, 32'h3);
    i_partner.pin_to(1'b1);
    idle(8);
    i_partner.pin_to(1'b0);
    idle(30);
    chk(32'(power_off_out), 32'h1);
    i_partner.pin_to(1'b1);
    wait_po(1'b0, 24);
    idle(2);
    chk(32'(irq), 32'h1);
    rd(swc_pkg::STS_OFF);
    chk(d, 32'h1);
    rd(swc_pkg::STS_OFF);
    chk(d, 32'h0);
    idle(2);
    chk(32'(irq), 32'h0);
    i_partner.pin_to(1'b0);
    idle(40);
    chk(32'(power_off_out), 32'h0);
    $display("test pin done");
  endtask
  task automatic t_modes();
    swc_pkg::swc_edge_type m [3];
    m = '{swc_pkg::EDGE_FALL, swc_pkg::EDGE_ANY, swc_pkg::EDGE_OFF};
    foreach (m[i])
    begin
      wr(swc_pkg::CFG_OFF, cfg(m[i], 4'h0, 1'b0));
      i_partner.pin_to(1'b1);
      idle(4);
      rd(swc_pkg::STS_OFF);
      go_off();
      i_partner.pin_to(1'b0);
      idle(40);
      chk(32'(power_off_out), 32'(m[i] == swc_pkg::EDGE_OFF));
      rd(swc_pkg::STS_OFF);
      chk(d, 32'(m[i] != swc_pkg::EDGE_OFF));
    end
    $display("test modes done");
  endtask
  task automatic t_alarm();
    i_partner.alarm_to(1'b1);
    idle(20);
    chk(32'(power_off_out), 32'h1);
    i_partner.alarm_to(1'b0);
    rd(swc_pkg::STS_OFF);
    chk(d, 32'h0);
    wr(swc_pkg::CFG_OFF, cfg(2'h0, 4'h0, 1'b1));
    i_partner.alarm_to(1'b1);
    wait_po(1'b0, 8);
    rd(swc_pkg::STS_OFF);
    chk(d, 32'h2);
    $display("test alarm done");
  endtask
  task automatic t_hold();
    wstrb <= 4'h0;
    wr(swc_pkg::CMD_OFF, {swc_pkg::KEY_VALUE, 24'h000001});
    wstrb <= 4'hF;
    idle(8);
    chk(32'(power_off_out), 32'h0);
    wr(swc_pkg::CFG_OFF, cfg(2'h1, 4'h0, 1'b0));
    go_off();
    chk(32'(supply_on), 32'h0);
    clk_en <= 1'b0;
    i_partner.pin_to(1'b1);
    idle(20);
    chk(32'(power_off_out), 32'h1);
    clk_en <= 1'b1;
    wait_po(1'b0, 8);
    chk(32'(supply_on), 32'h1);
    rd(swc_pkg::STS_OFF);
    chk(d, 32'h1);
    go_off();
    rst <= 1'b1;
    idle(2);
    chk(32'(power_off_out), 32'h0);
    rst <= 1'b0;
    rd(swc_pkg::CFG_OFF);
    chk(d, swc_pkg::CFG_RESET);
    $display("test hold done");
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #(40 * 30000);
    miscompares++;
    report_and_stop();
  end
  initial
  begin
    rst = 1'b1;
    clk_en = 1'b1;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_key();
    t_pin();
    t_modes();
    t_alarm();
    t_hold();
    report_and_stop();
  end
endmodule // swc_top_bench
